/* File: lcd_link_pkg.sv */
// Purpose: shared constants of the LCD host port link and its controller
// Assumes: pclk at 100 MHz on both ends
// Notes:   strap codes are {host_mode_sel_a, host_mode_sel_b}
package lcd_link_pkg;
    // Host interface strap codes
    localparam logic [1:0] MODE_8080   = 2'h1;
    localparam logic [1:0] MODE_6800   = 2'h3;
    localparam logic [1:0] MODE_SERIAL = 2'h2;
    localparam logic [1:0] MODE_RESET  = 2'h0;
    // Status byte layout
    localparam int         STAT_BUSY_BIT = 7;
    // Serial pin positions
    localparam int         SER_DATA_BIT = 7;
    localparam int         SER_CLK_BIT  = 6;
    localparam logic [2:0] SER_LAST_BIT = 3'h7;
    // Timing, in ns, and derived cycle counts
    localparam int         CLK_NS       = 10;
    localparam int         BUSY_NS      = 200;
    localparam int         SETUP_NS     = 30;
    localparam int         STROBE_NS    = 150;
    localparam int         HOLD_NS      = 30;
    localparam int         SCLK_HALF_NS = 80;
    localparam logic [7:0] BUSY_CYC      = 8'((BUSY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SETUP_CYC     = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] STROBE_CYC    = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] HOLD_CYC      = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
    // Controller register map (APB byte offsets)
    localparam logic [7:0]  OFF_CTRL = 8'h00;
    localparam logic [7:0]  OFF_CMD  = 8'h04;
    localparam logic [7:0]  OFF_STAT = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    // CTRL fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RST_BIT  = 2;
    // CMD fields
    localparam int CMD_CD_BIT = 8;
    localparam int CMD_RD_BIT = 9;
    // STAT fields
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_RDATA_LSB  = 8;
endpackage

/* File: lcd_link_if.sv */
// Purpose: pins between the microprocessor side and the LCD driver port
// Assumes: data bus pulled high when nobody drives
// Notes:   resolves the shared data bus from the two enables
`timescale 1ns/100ps
interface lcd_link_if;
    logic       host_mode_sel_a;
    logic       host_mode_sel_b;
    logic       chip_sel_low_active;
    logic       chip_sel_high_active;
    logic       cmd_data_sel;
    logic       rd_strobe;
    logic       wr_strobe;
    logic       reset_n;
    logic [7:0] host_dout;
    logic       host_doe;
    logic [7:0] dev_dout;
    logic       dev_doe;
    logic [7:0] data;

    // Wire level of the shared data bus
    assign data = dev_doe ? dev_dout : (host_doe ? host_dout : 8'hFF);

    modport device (
        input  host_mode_sel_a, host_mode_sel_b, chip_sel_low_active, chip_sel_high_active,
        input  cmd_data_sel, rd_strobe, wr_strobe, reset_n, data,
        output dev_dout, dev_doe
    );
    modport host (
        output host_mode_sel_a, host_mode_sel_b, chip_sel_low_active, chip_sel_high_active,
        output cmd_data_sel, rd_strobe, wr_strobe, reset_n, host_dout, host_doe,
        input  data
    );
endinterface

/* File: sync_2ff.sv */
// Purpose: two-stage synchroniser for a bundle of pins
// Assumes: bits are independent levels
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module sync_2ff #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // Two flip-flop chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // sync_2ff

/* File: lcd_device_end.sv */
// Purpose: host port of a dot-matrix LCD driver (parallel 8080/6800 or serial)
// Assumes: memory holds mem_rdata valid in the same cycle that mem_rd_req is high
// Notes:   all pins pass sync_2ff; strobes are found by edge detection
// Behaviour
// RULE1 - Straps pick 8080, 6800, serial or reset
// RULE2 - Serial mode: no readback, D0-D5 undriven
// RULE3 - Host holds strobes steady in serial mode
// RULE4 - Host raises straps together or first first
// RULE5 - Select low command, high display data
// RULE6 - Deselected: float bus, ignore control inputs
// RULE7 - Reset taken regardless of chip select
// RULE8 - 8080: drive on read low, capture write
// RULE9 - 6800: act while enable high, direction line
// RULE10 - Decode data/status read, data/command write
// RULE11 - Serial: 8-bit shifter, 3-bit counter, selected
// RULE12 - Deselect clears shifter and counter
// RULE13 - D7 data, D6 clock, MSB first, rising
// RULE14 - Byte processed on every eighth rising clock
// RULE15 - Select sampled at eighth clock edge
// RULE16 - Data read pipelined through holder, dummy first
// RULE17 - Written byte held then committed before next
// RULE18 - Parallel modes: 8-bit bidirectional data port
// RULE19 - Busy accepts status reads only, flag D7
// RULE20 - Host dummy reads after address or write
// RULE21 - Counter wraps after eighth bit
`timescale 1ns/100ps
module lcd_device_end
    import lcd_link_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    lcd_link_if.device      link,
    input  wire logic [7:0] mem_rdata,
    input  wire logic [6:0] status_flags,
    output logic            wr_valid,
    output logic            wr_is_data,
    output logic [7:0]      wr_byte,
    output logic            mem_rd_req,
    output logic            held_in_reset
);
    logic [15:0] pins_raw;
    logic [15:0] pins_syn;
    logic [1:0]  mode;
    logic        s_csl;
    logic        s_csh;
    logic        s_cd;
    logic        s_rd;
    logic        s_wr;
    logic        s_rstn;
    logic [7:0]  s_d;
    logic        hold_rst;
    logic        cs_act;
    logic        is_8080;
    logic        is_6800;
    logic        is_ser;
    logic        rd_prev_q;
    logic        wr_prev_q;
    logic        sclk_prev_q;
    logic        rd_start;
    logic        rd_level;
    logic        par_wr;
    logic        sclk_rise;
    logic        ser_wr;
    logic        wr_event;
    logic [7:0]  wr_data;
    logic [7:0]  holder_q;
    logic [7:0]  busy_cnt_q;
    logic        busy;
    logic [7:0]  shift_q;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  dout_q;
    logic        doe_q;

    // Every pin crosses into pclk first
    assign pins_raw = {link.host_mode_sel_a, link.host_mode_sel_b, link.chip_sel_low_active,
                       link.chip_sel_high_active, link.cmd_data_sel, link.rd_strobe,
                       link.wr_strobe, link.reset_n, link.data};

    sync_2ff #(
        .WIDTH(16)
    ) u_pin_sync (
        .pclk   (pclk),
        .presetn(presetn),
        .d      (pins_raw),
        .q      (pins_syn)
    );

    assign mode   = pins_syn[15:14];
    assign s_csl  = pins_syn[13];
    assign s_csh  = pins_syn[12];
    assign s_cd   = pins_syn[11];
    assign s_rd   = pins_syn[10];
    assign s_wr   = pins_syn[9];
    assign s_rstn = pins_syn[8];
    assign s_d    = pins_syn[7:0];

    // Mode decode and internal hold-in-reset
    assign is_8080  = (mode == MODE_8080);                       // [RULE1]
    assign is_6800  = (mode == MODE_6800);                       // [RULE1]
    assign is_ser   = (mode == MODE_SERIAL);                     // [RULE1]
    assign hold_rst = (mode == MODE_RESET) || !s_rstn;           // [RULE1] [RULE7]
    assign cs_act   = !s_csl && s_csh && !hold_rst;              // [RULE6]

    // Read start and drive window per bus style
    assign rd_start = cs_act && ((is_8080 && !s_rd && rd_prev_q)             // [RULE8]
                              || (is_6800 && s_rd && !rd_prev_q && s_wr));   // [RULE9]
    assign rd_level = cs_act && ((is_8080 && !s_rd) || (is_6800 && s_rd && s_wr)); // [RULE18]

    // Write taken at the trailing strobe edge
    assign par_wr = cs_act && ((is_8080 && s_wr && !wr_prev_q)               // [RULE8]
                            || (is_6800 && !s_rd && rd_prev_q && !s_wr));    // [RULE9]

    // Serial clock on D6, byte done on eighth rising edge
    assign sclk_rise = is_ser && cs_act && s_d[SER_CLK_BIT] && !sclk_prev_q;  // [RULE13]
    assign ser_wr    = sclk_rise && (bit_cnt_q == SER_LAST_BIT);              // [RULE14]
    assign wr_event  = (par_wr || ser_wr) && !busy;                           // [RULE19]
    assign wr_data   = ser_wr ? {shift_q[6:0], s_d[SER_DATA_BIT]} : s_d;      // [RULE14]
    assign busy      = (busy_cnt_q != 8'h00);

    // Strobe history for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_prev_q   <= 1'b1;
            wr_prev_q   <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            rd_prev_q   <= s_rd;
            wr_prev_q   <= s_wr;
            sclk_prev_q <= s_d[SER_CLK_BIT];
        end
    end

    // Busy time after each accepted write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_q <= 8'h00;
        end else if (hold_rst) begin
            busy_cnt_q <= 8'h00;
        end else if (wr_event) begin
            busy_cnt_q <= BUSY_CYC;                                  // [RULE19]
        end else if (busy) begin
            busy_cnt_q <= busy_cnt_q - 8'h01;
        end
    end

    // Serial shifter and bit counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q   <= 8'h00;
            bit_cnt_q <= 3'h0;
        end else if (!cs_act || !is_ser) begin
            shift_q   <= 8'h00;                                      // [RULE12]
            bit_cnt_q <= 3'h0;                                       // [RULE12]
        end else if (sclk_rise) begin
            shift_q   <= {shift_q[6:0], s_d[SER_DATA_BIT]};          // [RULE11] [RULE13]
            bit_cnt_q <= bit_cnt_q + 3'h1;                           // [RULE11] [RULE21]
        end
    end

    // Bus holder: display-data reads load it, display-data writes park their byte in it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            holder_q <= 8'h00;
        end else if (hold_rst) begin
            holder_q <= 8'h00;
        end else if (mem_rd_req) begin
            holder_q <= mem_rdata;                                   // [RULE16]
        end else if (wr_event && s_cd) begin
            holder_q <= wr_data;                                     // [RULE17]
        end
    end

    // Read data and drive enable toward the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_q <= 8'h00;
            doe_q  <= 1'b0;
        end else begin
            doe_q <= rd_level && !is_ser;                            // [RULE2] [RULE6] [RULE8]
            if (rd_start && !s_cd) begin
                dout_q <= {busy, status_flags};                      // [RULE10] [RULE19]
            end else if (rd_start && s_cd && !busy) begin
                dout_q <= holder_q;                                  // [RULE10] [RULE16]
            end
        end
    end

    // Memory read request, one per display-data read taken while not busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rd_req <= 1'b0;
        end else begin
            mem_rd_req <= rd_start && s_cd && !busy;                 // [RULE16] [RULE19]
        end
    end

    // Write pulse toward command decoder or display memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_valid   <= 1'b0;
            wr_is_data <= 1'b0;
            wr_byte    <= 8'h00;
        end else begin
            wr_valid <= wr_event;                                    // [RULE17]
            if (wr_event) begin
                wr_is_data <= s_cd;                                  // [RULE5] [RULE10] [RULE15]
                wr_byte    <= wr_data;
            end
        end
    end

    // Reset state flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_in_reset <= 1'b1;
        end else begin
            held_in_reset <= hold_rst;                               // [RULE7]
        end
    end

    assign link.dev_dout = dout_q;
    assign link.dev_doe  = doe_q;
endmodule // lcd_device_end

/* File: lcd_host_end.sv */
// Purpose: APB-driven microprocessor side of the LCD host port
// Assumes: one transfer at a time, posted through CMD
// Notes:   reads in serial mode are dropped; STAT shows activity
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
module lcd_host_end
    import lcd_link_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    lcd_link_if.host         link
);
    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_SETUP  = 5'b00010,
        S_STROBE = 5'b00100,
        S_SHIFT  = 5'b01000,
        S_HOLD   = 5'b10000
    } host_state_t;

    host_state_t state_q;
    logic [31:0] ctrl_q;
    logic [7:0]  tx_q;
    logic        is_rd_q;
    logic [7:0]  rdata_q;
    logic [7:0]  cnt_q;
    logic [3:0]  bit_q;
    logic [7:0]  d_syn;
    logic [1:0]  mode;
    logic        access;
    logic        start;
    logic        mapped;
    logic        cnt_done;
    logic        csl_q;
    logic        csh_q;
    logic        cd_q;
    logic        rd_q;
    logic        wr_q;
    logic [7:0]  dout_q;
    logic        doe_q;

    sync_2ff #(
        .WIDTH(8)
    ) u_data_sync (
        .pclk   (pclk),
        .presetn(presetn),
        .d      (link.data),
        .q      (d_syn)
    );

    assign mode     = ctrl_q[CTRL_MODE_LSB +: 2];
    assign access   = psel && penable && pready;
    assign mapped   = (paddr == OFF_CTRL) || (paddr == OFF_CMD) || (paddr == OFF_STAT);
    assign start    = access && pwrite && (paddr == OFF_CMD) && (state_q == S_IDLE);
    assign cnt_done = (cnt_q == 8'h01);

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready) begin
                case (paddr)
                    OFF_CTRL: prdata <= ctrl_q;
                    OFF_STAT: prdata <= {16'h0000, rdata_q, 7'h00, state_q != S_IDLE};
                    default:  prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Straps written as one field so both move at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (access && pwrite && paddr == OFF_CTRL) begin
            ctrl_q <= {29'h0, pwdata[2:0]};                          // [RULE4]
        end
    end

    // Transfer sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            cnt_q   <= 8'h00;
            bit_q   <= 4'h0;
            tx_q    <= 8'h00;
            is_rd_q <= 1'b0;
            rdata_q <= 8'h00;
            csl_q   <= 1'b1;
            csh_q   <= 1'b0;
            cd_q    <= 1'b0;
            rd_q    <= 1'b1;
            wr_q    <= 1'b1;
            dout_q  <= 8'h00;
            doe_q   <= 1'b0;
        end else begin
            if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
            case (state_q)
                S_IDLE: begin
                    rd_q <= (mode == MODE_6800) ? 1'b0 : 1'b1;       // [RULE3] [RULE9]
                    wr_q <= 1'b1;
                    if (start && !(pwdata[CMD_RD_BIT] && mode == MODE_SERIAL)) begin
                        state_q <= S_SETUP;
                        cnt_q   <= SETUP_CYC;
                        tx_q    <= pwdata[7:0];
                        is_rd_q <= pwdata[CMD_RD_BIT];
                        cd_q    <= pwdata[CMD_CD_BIT];               // [RULE5]
                        csl_q   <= 1'b0;
                        csh_q   <= 1'b1;
                        wr_q    <= (mode == MODE_6800) ? pwdata[CMD_RD_BIT] : 1'b1;
                        doe_q   <= !pwdata[CMD_RD_BIT];
                        dout_q  <= (mode == MODE_SERIAL) ? 8'h00 : pwdata[7:0];
                        bit_q   <= 4'h0;
                    end
                end
                S_SETUP: begin
                    if (cnt_done) begin
                        if (mode == MODE_SERIAL) begin
                            state_q <= S_SHIFT;
                            cnt_q   <= SCLK_HALF_CYC;
                            dout_q[SER_DATA_BIT] <= tx_q[7];         // [RULE13]
                        end else begin
                            state_q <= S_STROBE;
                            cnt_q   <= STROBE_CYC;
                            if (mode == MODE_6800) begin
                                rd_q <= 1'b1;                        // [RULE9]
                            end else if (is_rd_q) begin
                                rd_q <= 1'b0;                        // [RULE8]
                            end else begin
                                wr_q <= 1'b0;                        // [RULE8]
                            end
                        end
                    end
                end
                S_STROBE: begin
                    if (cnt_done) begin
                        if (is_rd_q) begin
                            rdata_q <= d_syn;
                        end
                        rd_q    <= (mode == MODE_6800) ? 1'b0 : 1'b1;
                        wr_q    <= (mode == MODE_6800) ? wr_q : 1'b1;  // R/W held past E fall [RULE9]
                        state_q <= S_HOLD;
                        cnt_q   <= HOLD_CYC;
                    end
                end
                S_SHIFT: begin
                    if (cnt_done) begin
                        cnt_q <= SCLK_HALF_CYC;
                        if (!dout_q[SER_CLK_BIT]) begin
                            dout_q[SER_CLK_BIT] <= 1'b1;             // [RULE13]
                        end else if (bit_q == 4'h7) begin
                            dout_q[SER_CLK_BIT] <= 1'b0;
                            state_q <= S_HOLD;
                            cnt_q   <= HOLD_CYC;
                        end else begin
                            dout_q[SER_CLK_BIT]  <= 1'b0;
                            dout_q[SER_DATA_BIT] <= tx_q[6 - bit_q[2:0]];
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                S_HOLD: begin
                    if (cnt_done) begin
                        state_q <= S_IDLE;
                        csl_q   <= 1'b1;
                        csh_q   <= 1'b0;
                        doe_q   <= 1'b0;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    assign link.host_mode_sel_a      = mode[1];
    assign link.host_mode_sel_b      = mode[0];
    assign link.reset_n              = !ctrl_q[CTRL_RST_BIT];
    assign link.chip_sel_low_active  = csl_q;
    assign link.chip_sel_high_active = csh_q;
    assign link.cmd_data_sel         = cd_q;
    assign link.rd_strobe            = rd_q;
    assign link.wr_strobe            = wr_q;
    assign link.host_dout            = dout_q;
    assign link.host_doe             = doe_q;
endmodule // lcd_host_end

/* File: lcd_link_monitor.sv */
// Purpose: pin-level checks on the LCD host port link
// Assumes: device samples pins through two sync flops
// Notes:   drive checks allow a few cycles of sync latency
`timescale 1ns/100ps
module lcd_link_monitor
    import lcd_link_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic host_mode_sel_a,
    input wire logic host_mode_sel_b,
    input wire logic chip_sel_low_active,
    input wire logic chip_sel_high_active,
    input wire logic cmd_data_sel,
    input wire logic rd_strobe,
    input wire logic wr_strobe,
    input wire logic dev_doe
);
    // Decoded select and strap mode
    wire       cs = !chip_sel_low_active && chip_sel_high_active;
    wire [1:0] m  = {host_mode_sel_a, host_mode_sel_b};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Status read held in each of the two parallel bus styles, 8080 and 6800
    sequence stat_8080_s;
        (cs && m == MODE_8080 && !rd_strobe && wr_strobe && !cmd_data_sel) [*6];
    endsequence
    sequence stat_6800_s;
        (cs && m == MODE_6800 && rd_strobe && wr_strobe && !cmd_data_sel) [*6];
    endsequence
    desel_float_a: assert property (!cs [*5] |-> !dev_doe)
        else $error("bus driven while deselected");
    serial_quiet_a: assert property (m == MODE_SERIAL [*5] |-> !dev_doe)
        else $error("bus driven in serial mode");
    strap_reset_a: assert property (m == MODE_RESET [*5] |-> !dev_doe)
        else $error("bus driven in strap reset");
    rd_idle_a: assert property ((m == MODE_8080 && rd_strobe) [*5] |-> !dev_doe)
        else $error("bus driven without read strobe");
    e_idle_a: assert property ((m == MODE_6800 && !rd_strobe) [*5] |-> !dev_doe)
        else $error("bus driven with enable low");
    write_dir_a: assert property ((m == MODE_6800 && !wr_strobe) [*5] |-> !dev_doe)
        else $error("bus driven in write cycle");
    stat_8080_a: assert property (stat_8080_s |-> dev_doe)
        else $error("status read not answered");
    stat_6800_a: assert property (stat_6800_s |-> dev_doe)
        else $error("status read not answered");
    serial_strobe_a: assert property (m == MODE_SERIAL [*4] |-> $stable(rd_strobe) && $stable(wr_strobe))
        else $error("strobes moved in serial mode");
endmodule // lcd_link_monitor

/* File: test_lcd_driver_host_interface.sv */
// Purpose: end-to-end bench of host and device ends of the LCD port
// Assumes: display memory modelled by random bytes
// Notes:   writes scored by a watcher on the device write port
`timescale 1ns/100ps
module test_lcd_driver_host_interface
    import lcd_link_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        wr_valid, wr_is_data, mem_rd_req, held_in_reset;
    logic [7:0]  paddr, mem_rdata, wr_byte, holder;
    logic [31:0] pwdata, prdata, r;
    logic [6:0]  status_flags;
    logic [8:0]  wq[$];
    logic [1:0]  md[3] = '{MODE_8080, MODE_6800, MODE_SERIAL};
    int          fail_count, n_tests, cyc, seed = 32'hd33e1d38;
    lcd_link_if lnk();
    lcd_host_end u_lcd_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lnk.host));
    lcd_device_end u_lcd_device_end (.pclk(pclk), .presetn(presetn), .link(lnk.device),
        .mem_rdata(mem_rdata), .status_flags(status_flags), .wr_valid(wr_valid),
        .wr_is_data(wr_is_data), .wr_byte(wr_byte), .mem_rd_req(mem_rd_req),
        .held_in_reset(held_in_reset));
    lcd_link_monitor u_lcd_link_monitor (.pclk(pclk), .presetn(presetn),
        .host_mode_sel_a(lnk.host_mode_sel_a), .host_mode_sel_b(lnk.host_mode_sel_b),
        .chip_sel_low_active(lnk.chip_sel_low_active), .chip_sel_high_active(lnk.chip_sel_high_active),
        .cmd_data_sel(lnk.cmd_data_sel), .rd_strobe(lnk.rd_strobe), .wr_strobe(lnk.wr_strobe),
        .dev_doe(lnk.dev_doe));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic conclude();
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, result left in r and e
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Poll until the link is idle, then let busy expire
    task automatic settle();
        int i;
        i = 0;
        do begin
            apb(1'b0, OFF_STAT, 32'h0);
            i++;
        end while (r[STAT_ACTIVE_BIT] !== 1'b0 && i < 200);
        if (r[STAT_ACTIVE_BIT] !== 1'b0) fail_count++;
        repeat (30) @(posedge pclk);
    endtask
    task automatic send(input logic cd, input logic [7:0] b);
        wq.push_back({cd, b});
        if (cd) holder = b;
        apb(1'b1, OFF_CMD, (32'(cd) << CMD_CD_BIT) | 32'(b));
        settle();
    endtask
    task automatic fetch(input logic cd, input logic [7:0] exp);
        apb(1'b1, OFF_CMD, (32'(cd) << CMD_CD_BIT) | (32'h1 << CMD_RD_BIT));
        settle();
        apb(1'b0, OFF_STAT, 32'h0);
        check(32'(r[15:8]), 32'(exp));
    endtask
    // Memory word stands before the request; the device takes it at the next edge
    always @(posedge pclk) begin
        if (mem_rd_req === 1'b1) begin
            holder = mem_rdata;
            mem_rdata <= 8'($random(seed));
        end
    end
    // Scores every write the device reports
    always @(posedge pclk) begin
        if (wr_valid === 1'b1) begin
            if (wq.size() == 0) check(32'h1, 32'h0);
            else check(32'({wr_is_data, wr_byte}), 32'(wq.pop_front()));
        end
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mem_rdata = 8'h00;
        holder = 8'h00;
        status_flags = 7'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, OFF_CTRL, 32'h0);
        check(r, CTRL_RST);
        apb(1'b0, 8'h0C, 32'h0);
        check(32'(e), 32'h1);
        // Writes in every bus style, reads where allowed
        foreach (md[i]) begin
            apb(1'b1, OFF_CTRL, 32'(md[i]));
            status_flags <= 7'($random(seed));
            for (int k = 0; k < 4; k++) send(k[0], 8'($random(seed)));
            if (md[i] != MODE_SERIAL) begin
                fetch(1'b0, {1'b0, status_flags});
                fetch(1'b1, holder);
                fetch(1'b1, holder);
            end
        end
        apb(1'b1, OFF_CMD, 32'h1 << CMD_RD_BIT);
        apb(1'b0, OFF_STAT, 32'h0);
        check(32'(r[STAT_ACTIVE_BIT]), 32'h0);
        settle();
        apb(1'b1, OFF_CTRL, 32'(MODE_RESET));
        repeat (6) @(posedge pclk);
        check(32'(held_in_reset), 32'h1);
        apb(1'b1, OFF_CTRL, 32'(MODE_8080) | (32'h1 << CTRL_RST_BIT));
        repeat (6) @(posedge pclk);
        check(32'(held_in_reset), 32'h1);
        apb(1'b1, OFF_CTRL, 32'(MODE_8080));
        repeat (6) @(posedge pclk);
        check(32'(held_in_reset), 32'h0);
        check(32'(wq.size()), 32'h0);
        conclude();
    end
endmodule // test_lcd_driver_host_interface
